// ### msq_cfg.svh
// Constants for the master status query handler.
// Assumes inclusion by the package, command store, handler, checker and bench files only.
`ifndef MSQ_CFG_SVH
`define MSQ_CFG_SVH

// ----------------------------------------
// Command block layout (zero-based word index)
// ----------------------------------------
`define MSQ_CMD_WORDS       4'hA
`define MSQ_IDX_LEN         4'h0
`define MSQ_IDX_WAIT        4'h1
`define MSQ_IDX_STYPE       4'h2
`define MSQ_IDX_SADDR       4'h3
`define MSQ_IDX_CODE        4'h6
`define MSQ_IDX_RTYPE       4'h7
`define MSQ_IDX_ROFS        4'h8
`define MSQ_IDX_RSIZE       4'h9

// ----------------------------------------
// Command values
// ----------------------------------------
`define MSQ_LEN_VAL         16'h0004
`define MSQ_CODE_VAL        16'h0002
`define MSQ_RSIZE_WORDS     16'h0009
`define MSQ_RSIZE_BYTES     16'h0012
`define MSQ_REPLY_WORDS     4'h9

// ----------------------------------------
// Memory type kinds and completion status
// ----------------------------------------
`define MSQ_MT_BIT          2'h0
`define MSQ_MT_BYTE         2'h1
`define MSQ_MT_WORD         2'h2
`define MSQ_STS_OK          16'h0001
`define MSQ_STS_BAD_CMD     16'h0002
`define MSQ_STS_BAD_SIZE    16'h0003

// ----------------------------------------
// Error source address limits
// ----------------------------------------
`define MSQ_ERR_ADDR_SELF   8'hFF
`define MSQ_ERR_ADDR_MAX    8'h7D

`endif

// ### msq_pkg.sv
// Types for the master status query handler.
// Assumes msq_cfg.svh sits in the include path.
`include "msq_cfg.svh"

package msq_pkg;

  // Control state of the shared memory interface
  typedef enum logic [7:0]
  {
    MSQ_CS_OFFLINE = 8'h00,
    MSQ_CS_STOP    = 8'h40,
    MSQ_CS_CLEAR   = 8'h80,
    MSQ_CS_OPERATE = 8'hC0
  } msq_ctrl_state_t;

  // Snapshot of master status sources
  typedef struct packed
  {
    logic [7:0]      global_bits;
    msq_ctrl_state_t ctrl_state;
    logic [7:0]      err_addr;
    logic [7:0]      err_code;
  } msq_status_t;

  // Controller memory write request
  typedef struct packed
  {
    logic [1:0]  kind;
    logic [7:0]  mem_type;
    logic [31:0] addr;
    logic [15:0] data;
  } msq_mem_wr_t;

  // Handler sequence, Gray along the usual path from IDLE up to DONE
  typedef enum logic [2:0]
  {
    MSQ_ST_IDLE  = 3'b000,
    MSQ_ST_LOAD  = 3'b001,
    MSQ_ST_CHECK = 3'b011,
    MSQ_ST_REPLY = 3'b010,
    MSQ_ST_STAT  = 3'b110,
    MSQ_ST_DONE  = 3'b111
  } msq_state_t;

endpackage

// ### msq_cmd_mem.sv
// Ten-word command block store with registered read data.
// Assumes one writer and one reader on the handler clock.
`include "msq_cfg.svh"

module msq_cmd_mem
(
  input  wire logic        clk_i,
  input  wire logic        wr_en_i,
  input  wire logic [3:0]  wr_idx_i,
  input  wire logic [15:0] wr_data_i,
  input  wire logic [3:0]  rd_idx_i,
  output logic      [15:0] rd_data_o
);
  import msq_pkg::*;

  logic [15:0] mem_ff [0:9];
  logic [15:0] rd_data_ff;

  // ----------------------------------------
  // Storage, no reset so it maps to RAM
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (wr_en_i && (wr_idx_i < `MSQ_CMD_WORDS))
      mem_ff[wr_idx_i] <= wr_data_i;
    if (rd_idx_i < `MSQ_CMD_WORDS)
      rd_data_ff <= mem_ff[rd_idx_i];
    else
      rd_data_ff <= 16'h0000;
  end

  assign rd_data_o = rd_data_ff;

endmodule

// ### msq_handler.sv
// Master status query handler: takes a command block, writes reply.
// Assumes a controller loads words 0..9 then pulses start; a memory
// port accepts one write per cycle when its ready is high.
`include "msq_cfg.svh"

module msq_handler
(
  input  wire logic                 CLK_I,
  input  wire logic                 RESETN_I,
  input  wire logic                 CMD_WR_I,
  input  wire logic [3:0]           CMD_IDX_I,
  input  wire logic [15:0]          CMD_DATA_I,
  input  wire logic                 CMD_START_I,
  input  wire logic [7:0]           MEM_TYPE_MAP_I,
  input  wire msq_pkg::msq_status_t STATUS_I,
  input  wire logic                 MEM_READY_I,
  output logic                      MEM_WR_O,
  output msq_pkg::msq_mem_wr_t      MEM_REQ_O,
  output logic                      BUSY_O,
  output logic                      DONE_O
);
  import msq_pkg::*;

  msq_state_t      state_ff, nxt_state;
  logic [3:0]      rd_idx_ff, nxt_rd_idx;
  logic [3:0]      cap_idx_ff, nxt_cap_idx;
  logic            cap_vld_ff, nxt_cap_vld;
  logic [15:0]     rd_data;
  logic [15:0]     stype_ff, nxt_stype;
  logic [15:0]     saddr_ff, nxt_saddr;
  logic [15:0]     code_ff, nxt_code;
  logic [15:0]     rtype_ff, nxt_rtype;
  logic [15:0]     rofs_ff, nxt_rofs;
  logic [15:0]     rsize_ff, nxt_rsize;
  logic [3:0]      word_ff, nxt_word;
  logic [15:0]     sts_ff, nxt_sts;
  msq_status_t     snap_ff, nxt_snap;
  msq_mem_wr_t     req_ff, nxt_req;
  logic            wr_ff, nxt_wr;
  logic            done_ff, nxt_done;
  logic [1:0]      rkind;

  // ----------------------------------------
  // Command block store
  // ----------------------------------------
  msq_cmd_mem u_cmd_mem
  (
    .clk_i     (CLK_I),
    .wr_en_i   (CMD_WR_I && (state_ff == MSQ_ST_IDLE)),
    .wr_idx_i  (CMD_IDX_I),
    .wr_data_i (CMD_DATA_I),
    .rd_idx_i  (rd_idx_ff),
    .rd_data_o (rd_data)
  );

  // Memory type code to addressing unit; map input names the byte-counted code
  function automatic logic [1:0] unit_of(input logic [15:0] mt);
    logic [1:0] k;
    k = `MSQ_MT_WORD;
    if (mt[7:0] == MEM_TYPE_MAP_I)
      k = `MSQ_MT_BYTE;
    else if (mt[0])
      k = `MSQ_MT_BIT;
    return k;
  endfunction

  // Address of reply word n in the unit of the memory type
  function automatic logic [31:0] addr_of(input logic [1:0] k, input logic [15:0] base, input logic [3:0] n);
    logic [31:0] a;
    a = {16'h0000, base};
    if (k == `MSQ_MT_BIT)
      a = a + {24'h000000, n, 4'h0};
    else if (k == `MSQ_MT_BYTE)
      a = a + {27'h0000000, n, 1'b0};
    else
      a = a + {28'h0000000, n};
    return a;
  endfunction

  // Process, not assign: the map input is read inside the function
  always_comb
    rkind = unit_of(rtype_ff);

  // ----------------------------------------
  // Reply word contents
  // ----------------------------------------
  function automatic logic [15:0] reply_of(input logic [3:0] n);
    logic [15:0] r;
    r = 16'h0000;                                 // Words 4..8 stay zero
    case (n)
      4'h0: r = `MSQ_CODE_VAL;
      4'h1: r = {8'h00, snap_ff.global_bits};     // Zero means no error
      4'h2: r = {8'h00, snap_ff.ctrl_state};
      4'h3: r = {snap_ff.err_code, snap_ff.err_addr};
      default: r = 16'h0000;
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // Sequencer next state
  // ----------------------------------------
  always_comb
  begin
    nxt_state   = state_ff;
    nxt_rd_idx  = rd_idx_ff;
    nxt_cap_idx = rd_idx_ff;
    nxt_cap_vld = 1'b0;
    nxt_stype   = stype_ff;
    nxt_saddr   = saddr_ff;
    nxt_code    = code_ff;
    nxt_rtype   = rtype_ff;
    nxt_rofs    = rofs_ff;
    nxt_rsize   = rsize_ff;
    nxt_word    = word_ff;
    nxt_sts     = sts_ff;
    nxt_snap    = snap_ff;
    nxt_req     = req_ff;
    nxt_wr      = wr_ff;
    nxt_done    = 1'b0;
    // Capture words one cycle after read address, memory read latency
    if (cap_vld_ff)
    begin
      if (cap_idx_ff == `MSQ_IDX_STYPE) nxt_stype = rd_data;
      if (cap_idx_ff == `MSQ_IDX_SADDR) nxt_saddr = rd_data;
      if (cap_idx_ff == `MSQ_IDX_CODE)  nxt_code  = rd_data;
      if (cap_idx_ff == `MSQ_IDX_RTYPE) nxt_rtype = rd_data;
      if (cap_idx_ff == `MSQ_IDX_ROFS)  nxt_rofs  = rd_data;
      if (cap_idx_ff == `MSQ_IDX_RSIZE) nxt_rsize = rd_data;
    end
    case (state_ff)
      MSQ_ST_IDLE:
      begin
        if (CMD_START_I)
        begin
          nxt_state  = MSQ_ST_LOAD;
          nxt_rd_idx = `MSQ_IDX_STYPE;   // Length, wait, reserved words unread
        end
      end
      MSQ_ST_LOAD:
      begin
        nxt_cap_vld = 1'b1;
        if (rd_idx_ff == `MSQ_IDX_SADDR)
          nxt_rd_idx = `MSQ_IDX_CODE;
        else if (rd_idx_ff == `MSQ_IDX_RSIZE)
          nxt_state = MSQ_ST_CHECK;
        else
          nxt_rd_idx = rd_idx_ff + 4'h1;
      end
      MSQ_ST_CHECK:
      begin
        if (!cap_vld_ff)
        begin
          nxt_word = 4'h0;
          nxt_snap = STATUS_I;           // Coherent snapshot for the whole reply
          if (code_ff != `MSQ_CODE_VAL)  // Other codes not answered here
          begin
            nxt_sts   = `MSQ_STS_BAD_CMD;
            nxt_state = MSQ_ST_STAT;
          end
          else if (rsize_ff < `MSQ_RSIZE_WORDS) // Too small to hold the reply
          begin
            nxt_sts   = `MSQ_STS_BAD_SIZE;
            nxt_state = MSQ_ST_STAT;
          end
          else
          begin
            nxt_sts   = `MSQ_STS_OK;
            nxt_state = MSQ_ST_REPLY;
          end
        end
      end
      MSQ_ST_REPLY:
      begin
        // Hold request until the memory takes it
        if (!wr_ff || MEM_READY_I)
        begin
          if (wr_ff && (word_ff == `MSQ_REPLY_WORDS - 4'h1))
          begin
            nxt_wr    = 1'b0;
            nxt_state = MSQ_ST_STAT;
          end
          else
          begin
            if (wr_ff)
              nxt_word = word_ff + 4'h1;
            nxt_wr       = 1'b1;
            nxt_req.kind = rkind;
            nxt_req.mem_type = rtype_ff[7:0];
            nxt_req.addr = addr_of(rkind, rofs_ff, nxt_word);
            nxt_req.data = reply_of(nxt_word);   // Registered together with its address
          end
        end
      end
      MSQ_ST_STAT:
      begin
        if (!wr_ff)
        begin
          nxt_wr           = 1'b1;
          nxt_req.kind     = unit_of(stype_ff);
          nxt_req.mem_type = stype_ff[7:0];
          nxt_req.addr     = {16'h0000, saddr_ff} + 32'h0000_0001; // Stored minus one
          nxt_req.data     = sts_ff;
        end
        else if (MEM_READY_I)
        begin
          nxt_wr    = 1'b0;
          nxt_state = MSQ_ST_DONE;
        end
      end
      MSQ_ST_DONE:
      begin
        nxt_done  = 1'b1;
        nxt_state = MSQ_ST_IDLE;
      end
      default: nxt_state = MSQ_ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      state_ff   <= MSQ_ST_IDLE;
      rd_idx_ff  <= 4'h0;
      cap_idx_ff <= 4'h0;
      cap_vld_ff <= 1'b0;
      stype_ff   <= 16'h0000;
      saddr_ff   <= 16'h0000;
      code_ff    <= 16'h0000;
      rtype_ff   <= 16'h0000;
      rofs_ff    <= 16'h0000;
      rsize_ff   <= 16'h0000;
      word_ff    <= 4'h0;
      sts_ff     <= 16'h0000;
      snap_ff    <= '0;
      req_ff     <= '0;
      wr_ff      <= 1'b0;
      done_ff    <= 1'b0;
    end
    else
    begin
      state_ff   <= nxt_state;
      rd_idx_ff  <= nxt_rd_idx;
      cap_idx_ff <= nxt_cap_idx;
      cap_vld_ff <= nxt_cap_vld;
      stype_ff   <= nxt_stype;
      saddr_ff   <= nxt_saddr;
      code_ff    <= nxt_code;
      rtype_ff   <= nxt_rtype;
      rofs_ff    <= nxt_rofs;
      rsize_ff   <= nxt_rsize;
      word_ff    <= nxt_word;
      sts_ff     <= nxt_sts;
      snap_ff    <= nxt_snap;
      req_ff     <= nxt_req;
      wr_ff      <= nxt_wr;
      done_ff    <= nxt_done;
    end
  end

  // Request fields all leave straight from flip-flops
  assign MEM_REQ_O = req_ff;
  assign MEM_WR_O = wr_ff;
  assign BUSY_O   = (state_ff != MSQ_ST_IDLE);
  assign DONE_O   = done_ff;

endmodule

// ### msq_handler_checker.sv
// Port-level checker for the master status query handler.
// Assumes the handler's top ports only; bound in below.
`include "msq_cfg.svh"

module msq_handler_checker
(
  input wire logic                 CLK_I,
  input wire logic                 RESETN_I,
  input wire logic                 CMD_WR_I,
  input wire logic [3:0]           CMD_IDX_I,
  input wire logic [15:0]          CMD_DATA_I,
  input wire logic                 CMD_START_I,
  input wire logic [7:0]           MEM_TYPE_MAP_I,
  input wire msq_pkg::msq_status_t STATUS_I,
  input wire logic                 MEM_READY_I,
  input wire logic                 MEM_WR_O,
  input wire msq_pkg::msq_mem_wr_t MEM_REQ_O,
  input wire logic                 BUSY_O,
  input wire logic                 DONE_O
);
  import msq_pkg::*;
  logic [3:0]  acc_ff;
  logic [31:0] prev_ff;
  logic [15:0] first_ff;
  logic [31:0] step;

  // Address step per reply word follows the unit of the memory kind
  assign step = (MEM_REQ_O.kind == 2'h2) ? 32'h1 : ((MEM_REQ_O.kind == 2'h1) ? 32'h2 : 32'h10);

  // Count accepted writes since the last taken start
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      acc_ff  <= 4'h0;
      prev_ff <= 32'h0;
      first_ff <= 16'h0000;
    end
    else
    begin
      if (CMD_START_I && !BUSY_O)
        acc_ff <= 4'h0;
      else if (MEM_WR_O && MEM_READY_I)
        acc_ff <= acc_ff + 4'h1;
      if (MEM_WR_O && MEM_READY_I)
        prev_ff <= MEM_REQ_O.addr;
      if (MEM_WR_O && MEM_READY_I && (acc_ff == 4'h0))
        first_ff <= MEM_REQ_O.data;
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);

  sequence s_stall;
    MEM_WR_O && !MEM_READY_I;
  endsequence
  sequence s_take;
    MEM_WR_O && MEM_READY_I;
  endsequence

  property p_hold;   s_stall |=> MEM_WR_O && $stable(MEM_REQ_O); endproperty
  // A second take means a reply runs, so the first take was the echo
  property p_echo;   s_take and (acc_ff == 4'h1) |-> first_ff == `MSQ_CODE_VAL; endproperty
  property p_global; s_take and (acc_ff == 4'h1) |-> MEM_REQ_O.data == {8'h00, STATUS_I.global_bits}; endproperty
  property p_ctrl;   s_take and (acc_ff == 4'h2) |-> MEM_REQ_O.data == {8'h00, STATUS_I.ctrl_state}; endproperty
  property p_err;    s_take and (acc_ff == 4'h3) |-> MEM_REQ_O.data == {STATUS_I.err_code, STATUS_I.err_addr};
  endproperty
  property p_rsvd;   s_take and (acc_ff inside {[4'h4:4'h8]}) |-> MEM_REQ_O.data == 16'h0000; endproperty
  property p_step;   s_take and (acc_ff inside {[4'h1:4'h8]}) |-> MEM_REQ_O.addr == prev_ff + step; endproperty
  property p_ok;     s_take and (acc_ff == 4'h9) |-> MEM_REQ_O.data == `MSQ_STS_OK; endproperty
  property p_idle;   !BUSY_O |-> !MEM_WR_O; endproperty
  property p_start;  CMD_START_I && !BUSY_O |=> BUSY_O; endproperty
  property p_done;   DONE_O |=> !DONE_O && !BUSY_O; endproperty

  a_hold:   assert property (p_hold)   else $error("reply write dropped while stalled");
  a_echo:   assert property (p_echo)   else $error("first reply word not the code echo");
  a_global: assert property (p_global) else $error("global state word wrong");
  a_ctrl:   assert property (p_ctrl)   else $error("control state word wrong");
  a_err:    assert property (p_err)    else $error("error source word wrong");
  a_rsvd:   assert property (p_rsvd)   else $error("reserved reply word not zero");
  a_step:   assert property (p_step)   else $error("reply address step wrong");
  a_ok:     assert property (p_ok)     else $error("completion status wrong");
  a_idle:   assert property (p_idle)   else $error("memory write while idle");
  a_start:  assert property (p_start)  else $error("start not taken");
  a_done:   assert property (p_done)   else $error("done not a single pulse");
endmodule

bind msq_handler msq_handler_checker u_msq_handler_checker (.CLK_I(CLK_I), .RESETN_I(RESETN_I),
  .CMD_WR_I(CMD_WR_I), .CMD_IDX_I(CMD_IDX_I), .CMD_DATA_I(CMD_DATA_I), .CMD_START_I(CMD_START_I),
  .MEM_TYPE_MAP_I(MEM_TYPE_MAP_I), .STATUS_I(STATUS_I), .MEM_READY_I(MEM_READY_I),
  .MEM_WR_O(MEM_WR_O), .MEM_REQ_O(MEM_REQ_O), .BUSY_O(BUSY_O), .DONE_O(DONE_O));

// ### msq_mem_model.sv
// Controller memory model that takes reply and status writes.
// Assumes one write port; slow mode accepts one write in four cycles.
module msq_mem_model
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 wr_i,
  input  wire msq_pkg::msq_mem_wr_t req_i,
  input  wire logic                 slow_i,
  output logic                      ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import msq_pkg::*;
  logic [1:0]  pace_ff;
  msq_mem_wr_t log_q[$];

  // Pacing counter; ready only moves just after an edge
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pace_ff <= 2'h0;
    else
      pace_ff <= pace_ff + 2'h1;
  end
  assign ready_o = !slow_i || (pace_ff == 2'h3);

  // Record every accepted write; unbounded queue holds the nine reply words of an answered query and the status
  always @(posedge clk_i)
  begin
    if (wr_i && ready_o)
      log_q.push_back(req_i);
  end
endmodule

// ### master_status_query_bench.sv
// Self-checking bench for the master status query handler.
// Assumes the package, handler, memory model and checker compile first.
`include "msq_cfg.svh"

module master_status_query_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import msq_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cmd_wr = 1'b0;
  logic [3:0]  cmd_idx = 4'h0;
  logic [15:0] cmd_data = 16'h0000;
  logic        cmd_start = 1'b0;
  msq_status_t st = '0;
  logic        slow = 1'b0;
  logic        mem_ready;
  logic        mem_wr;
  msq_mem_wr_t mem_req;
  logic        busy;
  logic        done;
  int          n_fail = 0;
  int          tests_run = 0;

  // 10 MHz clock
  always #50 clk = ~clk;

  msq_handler u_msq_handler (.CLK_I(clk), .RESETN_I(rst_n), .CMD_WR_I(cmd_wr), .CMD_IDX_I(cmd_idx),
    .CMD_DATA_I(cmd_data), .CMD_START_I(cmd_start), .MEM_TYPE_MAP_I(8'h46), .STATUS_I(st),
    .MEM_READY_I(mem_ready), .MEM_WR_O(mem_wr), .MEM_REQ_O(mem_req), .BUSY_O(busy), .DONE_O(done));
  msq_mem_model u_msq_mem_model (.clk_i(clk), .rst_n_i(rst_n), .wr_i(mem_wr), .req_i(mem_req),
    .slow_i(slow), .ready_o(mem_ready));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic put(input logic [3:0] i, input logic [15:0] d);
    @(negedge clk);
    cmd_wr = 1'b1;
    cmd_idx = i;
    cmd_data = d;
    @(negedge clk);
    cmd_wr = 1'b0;
  endtask

  // Status goes to word address 10; reserved words hold junk on purpose
  task automatic load(input logic [7:0] rt, input logic [15:0] ofs, input logic [15:0] code,
                      input logic [15:0] sz);
    put(4'h0, `MSQ_LEN_VAL);
    put(4'h1, 16'h0000);
    put(4'h2, 16'h0008);
    put(4'h3, 16'h0009);
    put(4'h4, 16'hFFFF);
    put(4'h5, 16'hA5A5);
    put(4'h6, code);
    put(4'h7, {8'h00, rt});
    put(4'h8, ofs);
    put(4'h9, sz);
  endtask

  // Start, optionally try to disturb the run while busy, wait for done
  task automatic go(input logic poke);
    int n;
    u_msq_mem_model.log_q.delete();
    @(negedge clk);
    cmd_start = 1'b1;
    @(negedge clk);
    cmd_start = 1'b0;
    if (poke)
    begin
      put(4'h6, 16'h0001);
      cmd_start = 1'b1;
      @(negedge clk);
      cmd_start = 1'b0;
    end
    n = 0;
    while (done !== 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    chk({31'h0, done}, 32'h1, "done pulse missing");
    repeat (20) @(negedge clk);
  endtask

  task automatic check(input int nrep, input logic [31:0] base, input logic [31:0] step,
                       input logic [1:0] kind, input logic [15:0] sts);
    logic [15:0] exp;
    msq_mem_wr_t w;
    chk(32'(u_msq_mem_model.log_q.size()), 32'(nrep + 1), "write count");
    for (int k = 0; k < u_msq_mem_model.log_q.size(); k++)
    begin
      w = u_msq_mem_model.log_q[k];
      exp = (k == 0) ? `MSQ_CODE_VAL : (k == 1) ? {8'h00, st.global_bits} : (k == 2) ?
            {8'h00, st.ctrl_state} : (k == 3) ? {st.err_code, st.err_addr} : 16'h0000;
      if (k < nrep)
      begin
        chk(w.addr, base + 32'(k) * step, "reply address");
        chk(32'(w.kind), 32'(kind), "reply unit");
        chk(32'(w.data), 32'(exp), "reply word");
      end
      else if (k == nrep)
      begin
        chk(w.addr, 32'hA, "status address");
        chk(32'(w.data), 32'(sts), "status value");
      end
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_word_operate();
    st = {8'h05, MSQ_CS_OPERATE, `MSQ_ERR_ADDR_SELF, 8'h36};
    load(8'h08, 16'd250, `MSQ_CODE_VAL, `MSQ_RSIZE_WORDS);
    go(1'b0);
    check(9, 32'd250, 32'h1, `MSQ_MT_WORD, `MSQ_STS_OK);
  endtask

  task automatic t_byte_clear();
    st = {8'h00, MSQ_CS_CLEAR, `MSQ_ERR_ADDR_MAX, 8'h00};
    load(8'h46, 16'd100, `MSQ_CODE_VAL, `MSQ_RSIZE_BYTES);
    go(1'b0);
    check(9, 32'd100, 32'h2, `MSQ_MT_BYTE, `MSQ_STS_OK);
  endtask

  // Slow memory plus a command write and start while busy
  task automatic t_bit_stop_stall();
    st = {8'h7F, MSQ_CS_STOP, 8'h03, 8'h32};
    slow = 1'b1;
    load(8'h47, 16'h0040, `MSQ_CODE_VAL, `MSQ_RSIZE_BYTES); // Discrete area size
    go(1'b1);
    slow = 1'b0;
    check(9, 32'd64, 32'h10, `MSQ_MT_BIT, `MSQ_STS_OK);
  endtask

  task automatic t_bad_code();
    st = {8'h01, MSQ_CS_OFFLINE, 8'h00, 8'h00};
    load(8'h08, 16'd250, 16'h0001, `MSQ_RSIZE_WORDS);
    go(1'b0);
    check(0, 32'h0, 32'h0, 2'h0, `MSQ_STS_BAD_CMD);
  endtask

  task automatic t_small_area();
    load(8'h08, 16'd250, `MSQ_CODE_VAL, 16'h0008);
    go(1'b0);
    check(0, 32'h0, 32'h0, 2'h0, `MSQ_STS_BAD_SIZE);
  endtask

  // Main sequence; reset spans 8 cycles
  initial
  begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk); // Let a first scan pass before any query
    t_word_operate();
    t_byte_clear();
    t_bit_stop_stall();
    t_bad_code();
    t_small_area();
    test_done();
  end

  // Watchdog: the run needs under 1000 cycles, allow 30000
  initial
  begin
    #3000000;
    n_fail++;
    test_done();
  end
endmodule
